// File: pkg/seh_pkg.sv
/*
  Constants, encodings and types for the serial EEPROM host controller.
  Assumes a 125 MHz core clock and a serial memory with the usual
  single-byte opcode set, a 12-bit array address and 32-byte pages.
*/
`default_nettype none

package seh_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_CYCLE_NS = 200;
  localparam int CS_LAG_NS = 100;
  localparam int CS_DESEL_NS = 100;
  localparam int PWRUP_MS = 1;
  // Least times round up to whole core clock cycles
  localparam int HALF_CYC =
    (SCK_CYCLE_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LAG_CYC = (CS_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESEL_CYC =
    (CS_DESEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_CYC_DEF = PWRUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 5;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_BUF = 8'h80;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_HOLD_BIT = 4;
  localparam int CTRL_WP_BIT = 5;
  localparam int CTRL_LEN_LSB = 8;
  localparam int CTRL_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_READY_BIT = 2;
  localparam int STAT_MEM_LSB = 8;
  localparam logic [2:0] CTRL_OP_RST = 3'h0;
  localparam logic [5:0] CTRL_LEN_RST = 6'h01;
  localparam logic CTRL_WP_RST = 1'b1;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Operations, opcodes and memory layout
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_SET_LATCH = 3'h0;
  localparam logic [2:0] OP_CLR_LATCH = 3'h1;
  localparam logic [2:0] OP_RD_STAT = 3'h2;
  localparam logic [2:0] OP_WR_STAT = 3'h3;
  localparam logic [2:0] OP_RD_ARRAY = 3'h4;
  localparam logic [2:0] OP_WR_ARRAY = 3'h5;
  localparam logic [7:0] set_write_latch_cmd = 8'h06;
  localparam logic [7:0] clear_write_latch_cmd = 8'h04;
  localparam logic [7:0] read_status_cmd = 8'h05;
  localparam logic [7:0] write_status_cmd = 8'h01;
  localparam logic [7:0] read_array_cmd = 8'h03;
  localparam logic [7:0] write_array_cmd = 8'h02;
  localparam int write_busy_flag = 0;
  localparam logic [7:0] STAT_WR_MASK = 8'h8C;
  localparam logic [6:0] PAGE_BYTES = 7'h20;
  localparam logic [5:0] ARRAY_HDR = 6'h03;

  typedef enum {ST_PWRUP, ST_IDLE, ST_SHIFT, ST_LAG, ST_GAP} seh_state_type;
  typedef enum {FK_LATCH, FK_MAIN, FK_POLL} seh_frame_type;

endpackage : seh_pkg

`default_nettype wire

// File: rtl/seh_sync.sv
/*
  Two-stage synchroniser for inputs from outside the core clock domain.
  Assumes the input may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module seh_sync #(
  parameter int WIDTH = 1
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : seh_sync

`default_nettype wire

// File: rtl/seh_host.sv
/*
  Host controller for a serial EEPROM: runs the serial frames for
  latch, status and array operations, ordered through Avalon-MM
  registers. Assumes the memory pins are wired straight to the part
  and that software waits for busy to clear before a new order.
*/
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Data rises stable, sampled on rising clock
// - Read sends opcode, 16-bit address, 12 used
// - Chip select high ends the transfer
// - Latch-set frame precedes every write
// - Latch-set frame holds exactly eight bits
// - Array write at least thirty-two clocks
// - Writes up to 32 bytes, all one page
// - Select rises only after whole bytes
// - Status write bits 0,1,4,5,6 zero
// - Pause changes only while clock low
// - Select must fall before any instruction
module seh_host
  import seh_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC_DEF
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mem_cs_n,
  output logic mem_sck,
  output logic mem_si,
  input wire logic mem_so,
  output logic mem_hold_n,
  output logic mem_wp_n
);

  localparam int PW = $clog2(PWRUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] LAG_LAST = CNT_W'(LAG_CYC - 1);
  localparam logic [CNT_W-1:0] DESEL_LAST = CNT_W'(DESEL_CYC - 1);

  if (PWRUP_CYCLES < 1 || HALF_CYC > 2**CNT_W || LAG_CYC > 2**CNT_W ||
      DESEL_CYC > 2**CNT_W)
  begin : g_bad_timing
    $error("seh_host: timing constant out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seh_state_type state, next_state;
  seh_frame_type frame, next_frame;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [PW-1:0] pwr_cnt;
  logic [2:0] bitc, next_bitc;
  logic [5:0] bytec, next_bytec;
  logic [7:0] txsh, next_txsh;
  logic [7:0] rxsh, next_rxsh;
  logic next_sck, next_si, next_cs_n, next_hold_n;
  logic busy, next_busy;
  logic frame_start;
  logic [2:0] ctrl_op;
  logic [5:0] ctrl_len;
  logic hold_req, wp_lvl, go_req, err;
  logic [15:0] addr_reg;
  logic [7:0] last_stat;
  logic [7:0] page_buf [32];
  logic so_s;
  logic [8:0] rcnt;

  seh_sync #(.WIDTH(1)) u_so_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(mem_so),
    .sync_out(so_s)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire bus_wr = avs_write && !avs_waitrequest;
  wire sel_ctrl = avs_address == REG_CTRL;
  wire sel_addr = avs_address == REG_ADDR;
  wire sel_stat = avs_address == REG_STAT;
  wire sel_buf = avs_address[7] == REG_BUF[7];
  wire [4:0] buf_idx = avs_address[6:2];
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] ctrl_word = {16'h0000, 2'h0, ctrl_len, 2'h0, wp_lvl,
                           hold_req, 1'b0, ctrl_op} << CTRL_OP_LSB;
  wire [31:0] ctrl_new = (ctrl_word & ~be_mask) |
                         (avs_writedata & be_mask);
  wire [31:0] addr_new = ({16'h0000, addr_reg} & ~be_mask) |
                         (avs_writedata & be_mask);
  wire [31:0] stat_word = {16'h0000, last_stat, 5'h00,
                           state != ST_PWRUP, err, busy | go_req};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_word :
                       sel_addr ? {16'h0000, addr_reg} :
                       sel_stat ? stat_word :
                       sel_buf ? {24'h000000, page_buf[buf_idx]} :
                       32'h00000000;
  wire ctrl_wr = bus_wr && sel_ctrl && !busy && !go_req;
  wire hold_wr = bus_wr && sel_ctrl && avs_byteenable[0];
  wire go_wr = bus_wr && sel_ctrl && avs_byteenable[3] &&
               avs_writedata[CTRL_GO_BIT];
  wire err_clr = bus_wr && sel_stat && avs_byteenable[0] &&
                 avs_writedata[STAT_ERR_BIT];

  // ----------------------------------------------------------------
  // Order checks
  // ----------------------------------------------------------------
  wire is_array = ctrl_op == OP_RD_ARRAY || ctrl_op == OP_WR_ARRAY;
  wire is_wr_op = ctrl_op == OP_WR_ARRAY || ctrl_op == OP_WR_STAT;
  wire [6:0] page_end = {2'h0, addr_reg[4:0]} + {1'b0, ctrl_len};
  // Reads may run across pages; only writes must stay inside one
  wire array_ok = ctrl_len != 6'h00 &&
                  (ctrl_op == OP_RD_ARRAY || page_end <= PAGE_BYTES);
  wire start_valid = ctrl_op <= OP_WR_ARRAY && (!is_array || array_ok);
  wire go_ok = go_req && state == ST_IDLE && start_valid;
  wire start_err = go_req && !go_ok;

  // ----------------------------------------------------------------
  // Frame content
  // ----------------------------------------------------------------
  function automatic logic [7:0] op_opcode(input logic [2:0] op);
    logic [7:0] code;
    code = read_status_cmd;
    unique case (op)
      OP_SET_LATCH: code = set_write_latch_cmd;
      OP_CLR_LATCH: code = clear_write_latch_cmd;
      OP_WR_STAT: code = write_status_cmd;
      OP_RD_ARRAY: code = read_array_cmd;
      OP_WR_ARRAY: code = write_array_cmd;
      default: code = read_status_cmd;
    endcase
    return code;
  endfunction : op_opcode

  wire main_main = frame == FK_MAIN;
  wire [5:0] main_bytes =
    is_array ? ARRAY_HDR + ctrl_len :
    (ctrl_op == OP_RD_STAT || ctrl_op == OP_WR_STAT) ? 6'h02 : 6'h01;
  wire [5:0] frame_bytes = frame == FK_LATCH ? 6'h01 :
                           frame == FK_POLL ? 6'h02 : main_bytes;
  wire last_byte = bytec == frame_bytes - 6'h01;
  wire [5:0] tx_idx = bytec + 6'h01;
  wire [4:0] wbuf_idx = 5'(tx_idx - ARRAY_HDR);
  wire [4:0] rbuf_idx = 5'(bytec - ARRAY_HDR);
  wire [7:0] tx_next =
    (is_array && tx_idx == 6'h01) ? {4'h0, addr_reg[11:8]} :
    (is_array && tx_idx == 6'h02) ? addr_reg[7:0] :
    (ctrl_op == OP_WR_STAT) ? page_buf[0] & STAT_WR_MASK :
    (ctrl_op == OP_WR_ARRAY) ? page_buf[wbuf_idx] :
    8'h00;
  wire [7:0] tx_first = next_frame == FK_LATCH ? set_write_latch_cmd :
                        next_frame == FK_POLL ? read_status_cmd :
                        op_opcode(ctrl_op);
  wire byte_done = state == ST_SHIFT && mem_sck && mem_hold_n &&
                   cnt == HALF_LAST && bitc == 3'h7;
  wire store_arr = byte_done && main_main && ctrl_op == OP_RD_ARRAY &&
                   bytec >= ARRAY_HDR;
  wire store_stat = byte_done && bytec == 6'h01 &&
                    (frame == FK_POLL || (main_main &&
                     ctrl_op == OP_RD_STAT));
  wire need_poll = (main_main && is_wr_op) ||
                   (frame == FK_POLL && last_stat[write_busy_flag]);

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_frame = frame;
    next_cnt = cnt;
    next_sck = mem_sck;
    next_si = mem_si;
    next_cs_n = mem_cs_n;
    next_hold_n = mem_hold_n;
    next_bitc = bitc;
    next_bytec = bytec;
    next_txsh = txsh;
    next_rxsh = rxsh;
    next_busy = busy;
    frame_start = 1'b0;
    unique case (state)
      ST_PWRUP:
        if (pwr_cnt == PW'(PWRUP_CYCLES - 1))
          next_state = ST_IDLE;
      ST_IDLE:
        if (go_ok)
        begin
          next_busy = 1'b1;
          next_frame = is_wr_op ? FK_LATCH : FK_MAIN;
          frame_start = 1'b1;
        end
      ST_SHIFT:
        if (!mem_sck && mem_hold_n == hold_req)
        begin
          next_hold_n = !hold_req;
          next_cnt = '0;
        end
        else if (!mem_hold_n)
          next_cnt = cnt;
        else if (cnt != HALF_LAST)
          next_cnt = cnt + 1'b1;
        else
        begin
          next_cnt = '0;
          if (!mem_sck)
          begin
            next_sck = 1'b1;
            next_rxsh = {rxsh[6:0], so_s};
          end
          else
          begin
            next_sck = 1'b0;
            next_bitc = bitc + 3'h1;
            if (bitc != 3'h7)
            begin
              next_txsh = {txsh[6:0], 1'b0};
              next_si = txsh[6];
            end
            else if (last_byte)
              next_state = ST_LAG;
            else
            begin
              next_bytec = tx_idx;
              next_txsh = tx_next;
              next_si = tx_next[7];
            end
          end
        end
      ST_LAG:
        if (cnt != LAG_LAST)
          next_cnt = cnt + 1'b1;
        else
        begin
          next_cnt = '0;
          next_cs_n = 1'b1;
          next_state = ST_GAP;
        end
      ST_GAP:
        if (cnt != DESEL_LAST)
          next_cnt = cnt + 1'b1;
        else if (frame == FK_LATCH)
        begin
          next_frame = FK_MAIN;
          frame_start = 1'b1;
        end
        else if (need_poll)
        begin
          next_frame = FK_POLL;
          frame_start = 1'b1;
        end
        else
        begin
          next_cnt = '0;
          next_busy = 1'b0;
          next_state = ST_IDLE;
        end
    endcase
    if (frame_start)
    begin
      next_state = ST_SHIFT;
      next_cs_n = 1'b0;
      next_sck = 1'b0;
      next_cnt = '0;
      next_bitc = 3'h0;
      next_bytec = 6'h00;
      next_txsh = tx_first;
      next_si = tx_first[7];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_PWRUP;
      frame <= FK_MAIN;
      cnt <= '0;
      bitc <= 3'h0;
      bytec <= 6'h00;
      txsh <= 8'h00;
      rxsh <= 8'h00;
      busy <= 1'b0;
      mem_cs_n <= 1'b1;
      mem_sck <= 1'b0;
      mem_si <= 1'b0;
      mem_hold_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      frame <= next_frame;
      cnt <= next_cnt;
      bitc <= next_bitc;
      bytec <= next_bytec;
      txsh <= next_txsh;
      rxsh <= next_rxsh;
      busy <= next_busy;
      mem_cs_n <= next_cs_n;
      mem_sck <= next_sck;
      mem_si <= next_si;
      mem_hold_n <= next_hold_n;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pwr_cnt <= '0;
    else if (state == ST_PWRUP)
      pwr_cnt <= pwr_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_op <= CTRL_OP_RST;
      ctrl_len <= CTRL_LEN_RST;
      wp_lvl <= CTRL_WP_RST;
      hold_req <= 1'b0;
      addr_reg <= ADDR_RST;
      go_req <= 1'b0;
      err <= 1'b0;
      last_stat <= 8'h00;
      mem_wp_n <= CTRL_WP_RST;
    end
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_op <= ctrl_new[CTRL_OP_LSB +: 3];
        ctrl_len <= ctrl_new[CTRL_LEN_LSB +: 6];
        wp_lvl <= ctrl_new[CTRL_WP_BIT];
      end
      if (hold_wr)
        hold_req <= avs_writedata[CTRL_HOLD_BIT];
      if (bus_wr && sel_addr && !busy && !go_req)
        addr_reg <= addr_new[15:0];
      go_req <= go_wr && !go_req && !busy;
      if (start_err || (go_wr && (busy || go_req)))
        err <= 1'b1;
      else if (err_clr)
        err <= 1'b0;
      if (store_stat)
        last_stat <= rxsh;
      if (state == ST_IDLE)
        mem_wp_n <= wp_lvl;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (store_arr)
      page_buf[rbuf_idx] <= rxsh;
    else if (bus_wr && sel_buf && avs_byteenable[0] && !busy)
      page_buf[buf_idx] <= avs_writedata[7:0];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rcnt <= 9'h000;
    else if (mem_cs_n)
      rcnt <= 9'h000;
    else if (next_sck && !mem_sck)
      rcnt <= rcnt + 9'h001;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_SI_STABLE: assert property (
    $rose(mem_sck) |-> $stable(mem_si))
    else $error("data changed at clock rise");
  AST_HOLD_SCK_LOW: assert property (
    $changed(mem_hold_n) |-> !mem_sck && $past(!mem_sck))
    else $error("pause changed with clock high");
  AST_IDLE_SCK: assert property (
    mem_cs_n |-> !mem_sck)
    else $error("clock high while deselected");
  AST_CS_WHOLE_BYTE: assert property (
    $rose(mem_cs_n) |-> rcnt[2:0] == 3'h0 && rcnt != 9'h000)
    else $error("select rose inside a byte");
  AST_LATCH_ALONE: assert property (
    $rose(mem_cs_n) && frame == FK_LATCH |-> rcnt == 9'h008)
    else $error("latch frame not eight clocks");
  AST_WRITE_MIN: assert property (
    $rose(mem_cs_n) && main_main && ctrl_op == OP_WR_ARRAY
    |-> rcnt >= 9'h020)
    else $error("array write below thirty-two clocks");
  AST_ADDR_TOP_ZERO: assert property (
    $rose(mem_sck) && main_main && is_array &&
    rcnt >= 9'h009 && rcnt <= 9'h00C |-> !mem_si)
    else $error("upper address nibble not zero");
  AST_WSTAT_ZERO: assert property (
    $rose(mem_sck) && main_main && ctrl_op == OP_WR_STAT &&
    (rcnt inside {9'h00A, 9'h00B, 9'h00C, 9'h00F, 9'h010}) |-> !mem_si)
    else $error("status write reserved bit set");
  AST_OPC_TOP_ZERO: assert property (
    $rose(mem_sck) && rcnt >= 9'h001 && rcnt <= 9'h005 |-> !mem_si)
    else $error("opcode upper bits not zero");
  AST_PAGE_FIT: assert property (
    $fell(mem_cs_n) && main_main && ctrl_op == OP_WR_ARRAY
    |-> page_end <= PAGE_BYTES)
    else $error("page write crosses page");

endmodule : seh_host

`default_nettype wire

// File: verif/seh_mem_model.sv
/*
  Behavioural serial EEPROM seen by the host controller.
  Assumes mode 0 frames; fault flags a host protocol slip.
*/
`timescale 1ns/1ps
`default_nettype none

module seh_mem_model
  import seh_pkg::*;
#(
  parameter int WR_NS = 20000
)(
  input wire logic mem_cs_n,
  input wire logic mem_sck,
  input wire logic mem_si,
  output logic mem_so,
  input wire logic mem_hold_n,
  input wire logic mem_wp_n,
  output logic fault
);
  logic [7:0] arr [4096];
  logic [11:0] pa [$];
  logic [7:0] pd [$];
  logic [7:0] op, sh, sr, nv, nvn;
  logic [15:0] adr;
  logic latch, busy, armed, last;
  int cnt;
  wire logic run = !mem_cs_n && mem_hold_n && armed;
  // Released output shows the inverse of its last bit
  assign mem_so = run ? last : !last;
  wire logic wr_op = op == write_array_cmd || op == write_status_cmd;

  initial
  begin
    foreach (arr[i]) arr[i] = 8'hFF;
    {op, sh, sr, nv, nvn, adr} = '0;
    {latch, busy, armed, last, fault} = '0;
    cnt = 0;
  end

  task automatic commit(input logic [7:0] o);
    busy = 1'b1;
    #(WR_NS);
    if (o == write_status_cmd && !(nv[7] && !mem_wp_n))
      nv = nvn & 8'h8C;
    foreach (pa[i])
      if (o == write_array_cmd && !(nv[3:2] == 2'h3 ||
          (nv[3:2] == 2'h2 && pa[i][11]) ||
          (nv[3:2] == 2'h1 && pa[i][11:10] == 2'h3)))
        arr[pa[i]] = pd[i];
    busy = 1'b0;
    latch = 1'b0;
  endtask : commit

  // ----------------
  // Serial edges
  // ----------------
  always @(negedge mem_cs_n)
  begin
    armed = 1'b1;
    cnt = 0;
    op = 8'h00;
  end

  always @(mem_hold_n)
    if (mem_sck) fault = 1'b1;

  always @(posedge mem_sck)
    if (run)
    begin
      sh = {sh[6:0], mem_si};
      cnt++;
      if (cnt == 8) op = sh;
      if (cnt == 16) adr[15:8] = sh;
      if (cnt == 16 && op == write_status_cmd) nvn = sh;
      if (cnt == 24) adr[7:0] = sh;
      if (cnt == 24 && op == write_array_cmd)
      begin
        pa.delete();
        pd.delete();
      end
      if (op == write_array_cmd && cnt >= 32 && cnt % 8 == 0)
      begin
        pa.push_back({adr[11:5], adr[4:0] + 5'((cnt - 32) / 8)});
        pd.push_back(sh);
      end
    end

  always @(negedge mem_sck)
    if (run)
    begin
      sr = {sr[6:0], 1'b0};
      if (op == read_array_cmd && cnt >= 24 && cnt % 8 == 0)
      begin
        sr = arr[adr[11:0]];
        adr[11:0] = adr[11:0] + 12'h001;
      end
      if (op == read_status_cmd && cnt >= 8 && cnt % 8 == 0)
        sr = {nv[7], 3'h0, nv[3:2], latch, busy};
      last = sr[7];
    end

  always @(posedge mem_cs_n)
    if (armed)
    begin : frame_end
      int need;
      need = op == write_array_cmd ? 32 : 16;
      if (cnt == 8 && op == set_write_latch_cmd) latch = 1'b1;
      if (cnt == 8 && op == clear_write_latch_cmd) latch = 1'b0;
      if (wr_op && (cnt % 8 != 0 || cnt < need)) fault = 1'b1;
      if (op == write_status_cmd && (nvn & 8'h73) != 8'h00)
        fault = 1'b1;
      if (pa.size() > 32) fault = 1'b1;
      if (wr_op && cnt % 8 == 0 && cnt >= need && latch && !busy)
        fork
          commit(op);
        join_none
    end
endmodule : seh_mem_model

`default_nettype wire

// File: verif/tb_top.sv
/*
  Self-checking bench for the serial EEPROM host controller.
  Assumes the behavioural memory model on the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import seh_pkg::*;
();
  localparam int PWR = 20;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, mem_cs_n, mem_sck, mem_si, mem_so;
  logic mem_hold_n, mem_wp_n, fault;
  int n_mismatch = 0;
  int n_checks = 0;
  integer seed = 39258;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  logic [7:0] shadow [4096];
  logic [7:0] nv_exp = 8'h00;
  logic saw = 1'b0;

  always #4 core_clk = ~core_clk;

  seh_host #(.PWRUP_CYCLES(PWR)) DUT (.core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_cs_n(mem_cs_n), .mem_sck(mem_sck), .mem_si(mem_si),
    .mem_so(mem_so), .mem_hold_n(mem_hold_n), .mem_wp_n(mem_wp_n));
  seh_mem_model MEM (.mem_cs_n(mem_cs_n), .mem_sck(mem_sck),
    .mem_si(mem_si), .mem_so(mem_so), .mem_hold_n(mem_hold_n),
    .mem_wp_n(mem_wp_n), .fault(fault));

  // ----------------
  // Bus and checks
  // ----------------
  task automatic check_word(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word

  task automatic bus(input logic rd, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    msk_q.push_back(32'hFFFF_FFFF);
    bus(1'b1, a, 32'h0, q);
  endtask : rd

  task automatic wait_idle();
    logic [31:0] q;
    q = 32'h1;
    while (q[0] !== 1'b0)
    begin
      exp_q.push_back(32'h0);
      msk_q.push_back(32'h0);
      bus(1'b1, REG_STAT, 32'h0, q);
      saw = saw | q[8];
    end
  endtask : wait_idle

  task automatic run_op(input logic [2:0] op, input logic [15:0] a,
    input logic [5:0] len);
    wr(REG_ADDR, {16'h0, a});
    wr(REG_CTRL, {1'b1, 17'h0, len, 5'h04, op});
  endtask : run_op

  task automatic op_stat(input logic [2:0] op, input logic [7:0] lb);
    run_op(op, 16'h0, 6'h01);
    wait_idle();
    run_op(OP_RD_STAT, 16'h0, 6'h01);
    wait_idle();
    rd(REG_STAT, {16'h0, nv_exp | lb, 8'h04});
  endtask : op_stat

  task automatic st_write(input logic [7:0] v);
    wr(REG_BUF, {24'h0, v});
    op_stat(OP_SET_LATCH, 8'h02);
    run_op(OP_WR_STAT, 16'h0, 6'h01);
    wait_idle();
    nv_exp = v & 8'h8C;
    rd(REG_STAT, {16'h0, nv_exp, 8'h04});
  endtask : st_write

  task automatic wr_page(input logic [15:0] a, input int len);
    logic [7:0] d;
    for (int i = 0; i < len; i++)
    begin
      d = 8'($random(seed));
      if (!(nv_exp[3:2] == 2'h1 && a[11:10] == 2'h3))
        shadow[a[11:0] + 12'(i)] = d;
      wr(REG_BUF + 8'(4 * i), {24'h0, d});
    end
    run_op(OP_WR_ARRAY, a, 6'(len));
    wait_idle();
    rd(REG_STAT, {16'h0, nv_exp, 8'h04});
  endtask : wr_page

  task automatic rd_page(input logic [15:0] a, input int len, input logic h);
    for (int i = 0; i < len; i++) wr(REG_BUF + 8'(4 * i), 32'h0);
    run_op(OP_RD_ARRAY, a, 6'(len));
    if (h)
    begin
      repeat (700) @(posedge core_clk);
      wr(REG_CTRL, 32'h0000_0034);
      repeat (200) @(posedge core_clk);
      check_word("hold_n sck", 32'h0, {30'h0, mem_hold_n, mem_sck});
      wr(REG_CTRL, 32'h0000_0024);
    end
    wait_idle();
    for (int i = 0; i < len; i++)
      rd(REG_BUF + 8'(4 * i), {24'h0, shadow[a[11:0] + 12'(i)]});
  endtask : rd_page

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge core_clk)
    if (nrst && avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      if (msk_q[0] != 32'h0)
        check_word($sformatf("readdata %h", avs_address), exp_q[0],
          avs_readdata);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    foreach (shadow[i]) shadow[i] = 8'hFF;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd(REG_CTRL, 32'h0000_0120);
    rd(REG_ADDR, 32'h0);
    run_op(OP_RD_STAT, 16'h0, 6'h01);
    rd(REG_STAT, 32'h0000_0002);
    check_word("pins", 32'h5, {29'h0, mem_cs_n, mem_sck, mem_hold_n});
    check_word("wp_n", 32'h1, {31'h0, mem_wp_n});
    rd(8'h40, 32'h0);
    repeat (PWR) @(posedge core_clk);
    wr(REG_STAT, 32'h0000_0002);
    rd(REG_STAT, 32'h0000_0004);
    op_stat(OP_SET_LATCH, 8'h02);
    op_stat(OP_CLR_LATCH, 8'h00);
    st_write(8'h77);
    wr_page(16'h0C00, 4);
    rd_page(16'hFC00, 4, 1'b0);
    st_write(8'h00);
    wr_page(16'h0FE0, 32);
    rd_page(16'h0FE0, 32, 1'b0);
    wr_page(16'h0000, 8);
    rd_page(16'h0FFC, 8, 1'b1);
    run_op(3'h6, 16'h0, 6'h01);
    rd(REG_STAT, {16'h0, nv_exp, 8'h06});
    wr(REG_STAT, 32'h0000_0002);
    run_op(OP_WR_ARRAY, 16'h001F, 6'h02);
    rd(REG_STAT, {16'h0, nv_exp, 8'h06});
    check_word("poll busy", 32'h1, {31'h0, saw});
    check_word("model fault", 32'h0, {31'h0, fault});
    report_and_stop();
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
